/* File: hdl/cacap_cfg.svh */
// register offsets, field positions, reset values and timing counts
`ifndef CACAP_CFG_SVH
`define CACAP_CFG_SVH
`define CACAP_OFF_CNT_LO 12'h000
`define CACAP_OFF_CNT_HI 12'h004
`define CACAP_OFF_MODE 12'h008
`define CACAP_OFF_CTRL 12'h00C
`define CACAP_OFF_INTEN 12'h010
`define CACAP_OFF_PINS 12'h014
`define CACAP_OFF_IRQ 12'h018
`define CACAP_OFF_MMODE0 12'h020
`define CACAP_OFF_CMP_LO0 12'h040
`define CACAP_OFF_CMP_HI0 12'h060
`define CACAP_MODE_TB_LSB 1
`define CACAP_MODE_OVF_IE 0
`define CACAP_MODE_IDLE 7
`define CACAP_MODE_WDOG 6
`define CACAP_MODE_RESET 8'h40
`define CACAP_CTRL_OVF 7
`define CACAP_CTRL_RUN 6
`define CACAP_INTEN_GLOBAL 0
`define CACAP_INTEN_ARRAY 1
`define CACAP_MMODE_RESET 8'h00
`define CACAP_DIV12 4'hB
`define CACAP_DIV4 4'h3
`define CACAP_MIN_LEVEL_NS 20
`define CACAP_CLK_NS 10
`define CACAP_MIN_LEVEL_CYC ((`CACAP_MIN_LEVEL_NS + `CACAP_CLK_NS - 1) / `CACAP_CLK_NS)
`endif

/* File: hdl/cacap_pkg.sv */
// types shared by the counter array files
package cacap_pkg;
    typedef enum logic [2:0] {
        CACAP_TB_DIV12 = 3'h0,
        CACAP_TB_DIV4 = 3'h1,
        CACAP_TB_TIMER0 = 3'h2,
        CACAP_TB_EXT_FALL = 3'h3,
        CACAP_TB_SYSCLK = 3'h4,
        CACAP_TB_XOSC8 = 3'h5
    } cacap_tb_e;
    typedef enum logic [5:0] {
        CACAP_M_OFF = 6'h01,
        CACAP_M_CAPTURE = 6'h02,
        CACAP_M_SWTIMER = 6'h04,
        CACAP_M_HSOUT = 6'h08,
        CACAP_M_FREQ = 6'h10,
        CACAP_M_PWM = 6'h20
    } cacap_mode_e;
    typedef struct packed {
        logic wide_pulse_select;
        logic compare_enable;
        logic rise_capture_enable;
        logic fall_capture_enable;
        logic compare_hit_enable;
        logic flip_on_hit_enable;
        logic pulse_width_enable;
        logic module_int_enable;
    } cacap_mmode_s;
endpackage

/* File: hdl/cacap_sync.sv */
// three-stage synchroniser with agreement check and edge pulses
module cacap_sync (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic async_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic [2:0] s_q;
    logic lvl_q;
    wire agree = (s_q[2] == s_q[1]);
    wire new_lvl = agree ? s_q[2] : lvl_q;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q <= 3'h0;
            lvl_q <= 1'b0;
        end else begin
            s_q <= {s_q[1:0], async_i};
            lvl_q <= new_lvl;
        end
    end
    // s_q[0] feeds only s_q[1]; a level must stand two cycles to be seen
    assign level_o = lvl_q;
    assign rise_o = new_lvl & ~lvl_q;
    assign fall_o = ~new_lvl & lvl_q;
endmodule

/* File: hdl/cacap_module.sv */
// one capture/compare module: mode decode, capture and event flag
`include "cacap_cfg.svh"
module cacap_module (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic io_line_i,
    input wire logic [15:0] count_i,
    input wire logic mode_we_i,
    input wire logic [7:0] wdata_i,
    input wire logic lo_we_i,
    input wire logic hi_we_i,
    input wire logic flag_clr_i,
    input wire logic flag_set_i,
    output cacap_pkg::cacap_mmode_s mode_o,
    output cacap_pkg::cacap_mode_e dec_o,
    output logic [15:0] capt_o,
    output logic flag_o,
    output logic irq_o,
    output logic pin_o
);
    cacap_pkg::cacap_mmode_s mode_q;
    logic [15:0] capt_q;
    logic flag_q;
    logic rise, fall;
    cacap_sync u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .async_i(io_line_i),
        .level_o(pin_o),
        .rise_o(rise),
        .fall_o(fall)
    );
    wire no_cmp = ~mode_q.compare_hit_enable & ~mode_q.flip_on_hit_enable
        & ~mode_q.pulse_width_enable;
    wire capt_mode = no_cmp & (mode_q.rise_capture_enable | mode_q.fall_capture_enable);
    wire cmp_ok = mode_q.compare_enable & ~mode_q.rise_capture_enable
        & ~mode_q.fall_capture_enable;
    assign dec_o = capt_mode ? cacap_pkg::CACAP_M_CAPTURE :
        !cmp_ok ? cacap_pkg::CACAP_M_OFF :
        (mode_q.flip_on_hit_enable & mode_q.pulse_width_enable) ? cacap_pkg::CACAP_M_FREQ :
        mode_q.pulse_width_enable ? cacap_pkg::CACAP_M_PWM :
        (mode_q.compare_hit_enable & mode_q.flip_on_hit_enable) ? cacap_pkg::CACAP_M_HSOUT :
        mode_q.compare_hit_enable ? cacap_pkg::CACAP_M_SWTIMER :
        cacap_pkg::CACAP_M_OFF;
    wire capt = capt_mode & ((rise & mode_q.rise_capture_enable)
        | (fall & mode_q.fall_capture_enable));
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_q <= `CACAP_MMODE_RESET;
            capt_q <= 16'h0000;
            flag_q <= 1'b0;
        end else begin
            if (mode_we_i) begin
                mode_q <= wdata_i;
            end else if (lo_we_i) begin
                mode_q.compare_enable <= 1'b0;
            end else if (hi_we_i) begin
                mode_q.compare_enable <= 1'b1;
            end
            if (capt) begin
                capt_q <= count_i;
            end else if (lo_we_i) begin
                capt_q[7:0] <= wdata_i;
            end else if (hi_we_i) begin
                capt_q[15:8] <= wdata_i;
            end
            // the event wins over a clear in the same cycle
            flag_q <= capt | flag_set_i | (flag_q & ~flag_clr_i);
        end
    end
    assign mode_o = mode_q;
    assign capt_o = capt_q;
    assign flag_o = flag_q;
    assign irq_o = flag_q & mode_q.module_int_enable;
    a_capture_loads: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        capt |=> capt_o == $past(count_i) && flag_o) else $error("capture lost");
    a_flag_sticky: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        flag_o && !flag_clr_i |=> flag_o) else $error("flag dropped");
    a_irq_gate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_o |-> flag_o && mode_q.module_int_enable) else $error("irq ungated");
    a_cmp_lo_clr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        lo_we_i && !mode_we_i |=> !mode_q.compare_enable) else $error("lo no clr");
    a_cmp_hi_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        hi_we_i && !lo_we_i && !mode_we_i |=> mode_q.compare_enable)
        else $error("hi no set");
endmodule

/* File: hdl/cacap_top.sv */
// counter array: apb registers, timebase, counter, watchdog lock, modules
`include "cacap_cfg.svh"
module cacap_top (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [4:0] module_io_line_i,
    input wire logic external_count_input_i,
    input wire logic timer0_overflow_i,
    input wire logic ext_osc_div8_i,
    input wire logic cpu_idle_i,
    output logic irq_o,
    output logic [15:0] count_o
);
    localparam int NMOD = 5;
    logic [15:0] cnt_q;
    logic [7:0] snap_q;
    logic [7:0] amode_q;
    logic run_q, ovf_q, gie_q, aie_q;
    logic [3:0] pre_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, irq_q;
    cacap_pkg::cacap_mmode_s mmode [NMOD];
    cacap_pkg::cacap_mode_e mdec [NMOD];
    logic [15:0] mcapt [NMOD];
    logic [NMOD-1:0] mflag, mirq, mpin;
    logic eci_fall, xosc_rise;
    // apb access phase ends one cycle after it starts; pready is registered and pulses once
    wire acc = psel_i & penable_i & ~pready_q;
    wire wr = acc & pwrite_i;
    wire rd = acc & ~pwrite_i;
    wire [7:0] wb = pwdata_i[7:0];
    wire hit_lo = (paddr_i == `CACAP_OFF_CNT_LO);
    wire hit_hi = (paddr_i == `CACAP_OFF_CNT_HI);
    wire hit_md = (paddr_i == `CACAP_OFF_MODE);
    wire hit_ct = (paddr_i == `CACAP_OFF_CTRL);
    wire hit_ie = (paddr_i == `CACAP_OFF_INTEN);
    wire hit_pn = (paddr_i == `CACAP_OFF_PINS);
    wire hit_iq = (paddr_i == `CACAP_OFF_IRQ);
    wire [11:0] mrel = paddr_i - `CACAP_OFF_MMODE0;
    wire [11:0] lrel = paddr_i - `CACAP_OFF_CMP_LO0;
    wire [11:0] hrel = paddr_i - `CACAP_OFF_CMP_HI0;
    wire hit_mm = (paddr_i >= `CACAP_OFF_MMODE0) && (mrel[1:0] == 2'h0) && (mrel < 12'h014);
    wire hit_cl = (paddr_i >= `CACAP_OFF_CMP_LO0) && (lrel[1:0] == 2'h0) && (lrel < 12'h014);
    wire hit_ch = (paddr_i >= `CACAP_OFF_CMP_HI0) && (hrel[1:0] == 2'h0) && (hrel < 12'h014);
    wire [2:0] midx = hit_mm ? mrel[4:2] : hit_cl ? lrel[4:2] : hrel[4:2];
    wire mapped = hit_lo | hit_hi | hit_md | hit_ct | hit_ie | hit_pn | hit_iq
        | hit_mm | hit_cl | hit_ch;
    wire wdog = amode_q[`CACAP_MODE_WDOG];
    wire [2:0] tbsel = amode_q[`CACAP_MODE_TB_LSB +: 3];
    // timebase selection
    wire pre_wrap = (tbsel == cacap_pkg::CACAP_TB_DIV12) ? (pre_q == `CACAP_DIV12) :
        (pre_q[1:0] == 2'(`CACAP_DIV4));
    wire tick = (tbsel == cacap_pkg::CACAP_TB_DIV12) ? pre_wrap :
        (tbsel == cacap_pkg::CACAP_TB_DIV4) ? pre_wrap :
        (tbsel == cacap_pkg::CACAP_TB_TIMER0) ? timer0_overflow_i :
        (tbsel == cacap_pkg::CACAP_TB_EXT_FALL) ? eci_fall :
        (tbsel == cacap_pkg::CACAP_TB_SYSCLK) ? 1'b1 :
        (tbsel == cacap_pkg::CACAP_TB_XOSC8) ? xosc_rise : 1'b0;
    // idle stop only matters when set; watchdog runs the counter without the run bit
    wire running = (run_q | wdog) & ~(cpu_idle_i & amode_q[`CACAP_MODE_IDLE]);
    wire adv = running & tick;
    wire wrap = adv & (cnt_q == 16'hFFFF);
    wire cnt_wr_ok = wr & ~wdog;
    cacap_sync u_eci (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .async_i(external_count_input_i),
        .level_o(),
        .rise_o(),
        .fall_o(eci_fall)
    );
    cacap_sync u_xosc (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .async_i(ext_osc_div8_i),
        .level_o(),
        .rise_o(xosc_rise),
        .fall_o()
    );
    genvar g;
    generate
        for (g = 0; g < NMOD; g++) begin : g_mod
            wire sel = (midx == 3'(g));
            cacap_module u_mod (
                .clk_i(clk_i),
                .reset_n_i(reset_n_i),
                .io_line_i(module_io_line_i[g]),
                .count_i(cnt_q),
                .mode_we_i(wr & hit_mm & sel),
                .wdata_i(wb),
                .lo_we_i(wr & hit_cl & sel),
                .hi_we_i(wr & hit_ch & sel),
                .flag_clr_i(wr & hit_ct & ~wb[g]),
                .flag_set_i(1'b0),
                .mode_o(mmode[g]),
                .dec_o(mdec[g]),
                .capt_o(mcapt[g]),
                .flag_o(mflag[g]),
                .irq_o(mirq[g]),
                .pin_o(mpin[g])
            );
        end
    endgenerate
    wire ovf_irq = ovf_q & amode_q[`CACAP_MODE_OVF_IE];
    wire irq_d = gie_q & aie_q & (ovf_irq | (|mirq));
    wire [7:0] ctrl_rd = {ovf_q, run_q & ~wdog ? 1'b1 : run_q, 1'b0, mflag};
    wire [7:0] mm_rd = mmode[midx];
    wire [31:0] rd_d = hit_lo ? {24'h0, cnt_q[7:0]} :
        hit_hi ? {24'h0, snap_q} :
        hit_md ? {24'h0, amode_q} :
        hit_ct ? {24'h0, ctrl_rd} :
        hit_ie ? {30'h0, aie_q, gie_q} :
        hit_pn ? {27'h0, mpin} :
        hit_iq ? {26'h0, ovf_irq, mirq} :
        hit_mm ? {24'h0, mm_rd} :
        hit_cl ? {24'h0, mcapt[midx][7:0]} :
        hit_ch ? {24'h0, mcapt[midx][15:8]} : 32'h0;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pre_q <= 4'h0;
        end else if (pre_wrap) begin
            pre_q <= 4'h0;
        end else begin
            pre_q <= pre_q + 4'h1;
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= 16'h0000;
        end else if (cnt_wr_ok && hit_lo) begin
            cnt_q[7:0] <= wb;
        end else if (cnt_wr_ok && hit_hi) begin
            cnt_q[15:8] <= wb;
        end else if (adv) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            snap_q <= 8'h00;
        end else if (rd && hit_lo) begin
            snap_q <= cnt_q[15:8];
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            amode_q <= `CACAP_MODE_RESET;
        end else if (wr && hit_md && wdog) begin
            // timebase and idle stop frozen while watchdog is on
            amode_q[`CACAP_MODE_WDOG] <= wb[`CACAP_MODE_WDOG];
            amode_q[`CACAP_MODE_OVF_IE] <= wb[`CACAP_MODE_OVF_IE];
        end else if (wr && hit_md) begin
            amode_q <= wb;
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_q <= 1'b0;
            ovf_q <= 1'b0;
            gie_q <= 1'b0;
            aie_q <= 1'b0;
        end else begin
            if (wr && hit_ct) begin
                run_q <= wb[`CACAP_CTRL_RUN];
            end
            // wrap wins over a software clear; hardware never clears it
            ovf_q <= wrap | (ovf_q & ~(wr & hit_ct & ~wb[`CACAP_CTRL_OVF]));
            if (wr && hit_ie) begin
                gie_q <= wb[`CACAP_INTEN_GLOBAL];
                aie_q <= wb[`CACAP_INTEN_ARRAY];
            end
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            prdata_q <= rd ? rd_d : 32'h0;
            pready_q <= acc;
            pslverr_q <= acc & ~mapped;
            irq_q <= irq_d;
        end
    end
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign irq_o = irq_q;
    assign count_o = cnt_q;
    a_wrap_sets_ovf: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wrap |=> ovf_q && cnt_q == 16'h0000) else $error("wrap no flag");
    a_irq_global: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_o |-> $past(gie_q) && $past(aie_q)) else $error("irq ungated");
    a_ovf_irq_en: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(irq_o) && mirq == 5'h0 |-> $past(amode_q[0])) else $error("ovf ie");
    a_wdog_lock: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wdog && !adv |=> $stable(cnt_q)) else $error("counter written");
    a_tb_frozen: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wdog |=> $stable(amode_q[3:1]) && $stable(amode_q[7])) else $error("tb moved");
    a_snap_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        rd && hit_lo |=> snap_q == $past(cnt_q[15:8])) else $error("no snapshot");
    // decode checked from the raw mode bits, not from the decoder's own terms
    a_dec_swtimer: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        mmode[0].compare_enable && mmode[0].compare_hit_enable
        && !mmode[0].flip_on_hit_enable && !mmode[0].pulse_width_enable
        && !mmode[0].rise_capture_enable && !mmode[0].fall_capture_enable
        |-> mdec[0] == cacap_pkg::CACAP_M_SWTIMER) else $error("swtimer decode");
endmodule

/* File: dv/cacap_src.sv */
// external sources for the module lines, count pin and oscillator input
module cacap_src (
    input wire logic clk_i,
    output logic [4:0] line_o,
    output logic ext_count_o,
    output logic osc_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        line_o = 5'h00;
        ext_count_o = 1'b1;
        osc_o = 1'b0;
    end
    // each level held three clocks, one more than needed, for margin
    task set_line(input int n, input logic lvl);
        @(posedge clk_i);
        line_o <= (line_o & ~(5'h01 << n)) | ({4'h0, lvl} << n);
        repeat (3) @(posedge clk_i);
    endtask
    // falls spaced four clocks apart, the fastest allowed
    task ext_falls(input int k);
        repeat (k) begin
            @(posedge clk_i);
            ext_count_o <= 1'b0;
            repeat (2) @(posedge clk_i);
            ext_count_o <= 1'b1;
            @(posedge clk_i);
        end
    endtask
    // oscillator runs only while the bench asks for edges
    task osc_rises(input int k);
        repeat (k) begin
            repeat (4) @(posedge clk_i);
            osc_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            osc_o <= 1'b0;
        end
    endtask
endmodule

/* File: dv/counter_array_capture_tb_top.sv */
// self-checking bench for the counter array
`include "cacap_cfg.svh"
module counter_array_capture_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, reset_n_i, psel, penable, pwrite, timer0_ovf, cpu_idle, err;
    logic pready_o, pslverr_o, irq_o, ext_cnt, osc;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata_o, rd;
    logic [4:0] lines;
    logic [15:0] count_o;
    int bad_count, checks, cycles;
    cacap_top i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .module_io_line_i(lines),
        .external_count_input_i(ext_cnt), .timer0_overflow_i(timer0_ovf),
        .ext_osc_div8_i(osc), .cpu_idle_i(cpu_idle), .irq_o(irq_o), .count_o(count_o));
    cacap_src i_src (.clk_i(clk_i), .line_o(lines), .ext_count_o(ext_cnt), .osc_o(osc));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task print_verdict;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // whole run needs well under this many clocks
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            print_verdict();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // counts under free-running prescalers only land within a window
    task chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
        end
        rd = prdata_o;
        err = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task pulse_t0;
        @(posedge clk_i);
        timer0_ovf <= 1'b1;
        @(posedge clk_i);
        timer0_ovf <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    function logic cap_hit(input logic [1:0] sel, input logic rising);
        return rising ? sel[1] : sel[0];
    endfunction
    function logic [31:0] cap_mode(input logic [1:0] sel);
        return {26'h0, sel, 4'h1};
    endfunction
    initial begin
        int k, w, div;
        logic [15:0] v, lo, hi;
        logic [1:0] sel;
        logic hit;
        {reset_n_i, psel, penable, pwrite, timer0_ovf, cpu_idle} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        bad_count = 0;
        checks = 0;
        cycles = 0;
        void'($urandom(66));
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd_chk(`CACAP_OFF_MODE, 32'h40);
        rd_chk(`CACAP_OFF_MMODE0, 32'h0);
        apb(1'b0, 12'hFFC, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        wr(`CACAP_OFF_MODE, 32'hC8);
        rd_chk(`CACAP_OFF_MODE, 32'h40);
        wr(`CACAP_OFF_CNT_HI, 32'h80);
        chk({31'h0, count_o[15]}, 32'h0);
        chk_rng(count_o, 16'h0001, 16'hFFFF);
        wr(`CACAP_OFF_MODE, 32'h00);
        $display("test reset done");
        for (int t = 0; t < 6; t++) begin
            wr(`CACAP_OFF_CTRL, 32'h0);
            wr(`CACAP_OFF_CNT_LO, 32'h0);
            wr(`CACAP_OFF_CNT_HI, 32'h0);
            wr(`CACAP_OFF_MODE, 32'(t) << 1);
            k = $urandom_range(3, 9);
            w = k * 12;
            div = (t == 0) ? 12 : (t == 1) ? 4 : 1;
            wr(`CACAP_OFF_CTRL, 32'h40);
            cpu_idle <= 1'b1;
            case (t)
                2: repeat (k) pulse_t0();
                3: i_src.ext_falls(k);
                5: i_src.osc_rises(k);
                default: repeat (w) @(posedge clk_i);
            endcase
            repeat (8) @(posedge clk_i);
            wr(`CACAP_OFF_CTRL, 32'h0);
            cpu_idle <= 1'b0;
            @(posedge clk_i);
            lo = (t == 2 || t == 3 || t == 5) ? 16'(k) : 16'((w + 8) / div - 1);
            hi = (t == 2 || t == 3 || t == 5) ? 16'(k) : 16'((w + 16) / div + 1);
            chk_rng(count_o, lo, hi);
        end
        $display("test timebase done");
        wr(`CACAP_OFF_MODE, 32'h04);
        wr(`CACAP_OFF_CNT_LO, 32'hFF);
        wr(`CACAP_OFF_CNT_HI, 32'h12);
        wr(`CACAP_OFF_CTRL, 32'h40);
        rd_chk(`CACAP_OFF_CNT_LO, 32'hFF);
        pulse_t0();
        chk({16'h0, count_o}, 32'h1300);
        rd_chk(`CACAP_OFF_CNT_HI, 32'h12);
        wr(`CACAP_OFF_CTRL, 32'h0);
        wr(`CACAP_OFF_CNT_LO, 32'hFF);
        wr(`CACAP_OFF_CNT_HI, 32'hFF);
        wr(`CACAP_OFF_MODE, 32'h05);
        wr(`CACAP_OFF_CTRL, 32'h40);
        pulse_t0();
        rd_chk(`CACAP_OFF_CTRL, 32'hC0);
        wr(`CACAP_OFF_INTEN, 32'h01);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        wr(`CACAP_OFF_INTEN, 32'h03);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h1);
        wr(`CACAP_OFF_MODE, 32'h04);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        repeat (20) @(posedge clk_i);
        rd_chk(`CACAP_OFF_CTRL, 32'hC0);
        wr(`CACAP_OFF_CTRL, 32'h1F);
        rd_chk(`CACAP_OFF_CTRL, 32'h0);
        $display("test overflow done");
        for (int n = 0; n < 5; n++) begin
            sel = 2'((n % 3) + 1);
            v = 16'($urandom_range(0, 65535));
            wr(`CACAP_OFF_CNT_LO, {24'h0, v[7:0]});
            wr(`CACAP_OFF_CNT_HI, {24'h0, v[15:8]});
            wr(`CACAP_OFF_MMODE0 + 12'(n * 4), cap_mode(sel));
            rd_chk(`CACAP_OFF_MMODE0 + 12'(n * 4), cap_mode(sel));
            for (int e = 1; e >= 0; e--) begin
                i_src.set_line(n, e[0]);
                repeat (6) @(posedge clk_i);
                hit = cap_hit(sel, e[0]);
                rd_chk(`CACAP_OFF_CTRL, 32'(hit) << n);
                chk({31'h0, irq_o}, {31'h0, hit});
                rd_chk(`CACAP_OFF_PINS, 32'(e[0]) << n);
                if (hit) begin
                    rd_chk(`CACAP_OFF_CMP_LO0 + 12'(n * 4), {24'h0, v[7:0]});
                    rd_chk(`CACAP_OFF_CMP_HI0 + 12'(n * 4), {24'h0, v[15:8]});
                end
                wr(`CACAP_OFF_CTRL, 32'h9F ^ (32'h1 << n));
            end
        end
        $display("test capture done");
        wr(`CACAP_OFF_CMP_HI0, 32'h34);
        rd_chk(`CACAP_OFF_MMODE0, 32'h51);
        wr(`CACAP_OFF_CMP_LO0, 32'h12);
        rd_chk(`CACAP_OFF_MMODE0, 32'h11);
        wr(`CACAP_OFF_MMODE0, 32'h48);
        rd_chk(`CACAP_OFF_MMODE0, 32'h48);
        $display("test compare enable done");
        wr(`CACAP_OFF_MODE, 32'h88);
        wr(`CACAP_OFF_CNT_LO, 32'h0);
        wr(`CACAP_OFF_CNT_HI, 32'h0);
        cpu_idle <= 1'b1;
        wr(`CACAP_OFF_CTRL, 32'h40);
        repeat (10) @(posedge clk_i);
        chk({16'h0, count_o}, 32'h0);
        cpu_idle <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk_rng(count_o, 16'h0008, 16'h000C);
        wr(`CACAP_OFF_CTRL, 32'h0);
        $display("test idle stop done");
        print_verdict();
    end
endmodule
